/* File: logic/tdt_pkg.sv */
// Package with register map, field layout and clock source codes of the triple down timer
package tdt_pkg;

	// Sizes
	localparam int TDT_NT = 3;
	localparam int TDT_CNT_W = 12;
	localparam int TDT_HI_W = 4;
	localparam int TDT_LO_W = 8;
	localparam int TDT_PRE_W = 16;
	localparam int TDT_IDX_W = 13;

	// Register indices; byte address is four times the index
	localparam logic [TDT_IDX_W-1:0] IDX_T1_HI = 13'h1010;
	localparam logic [TDT_IDX_W-1:0] IDX_T1_LO = 13'h1011;
	localparam logic [TDT_IDX_W-1:0] IDX_T1_CTRL = 13'h1012;
	localparam logic [TDT_IDX_W-1:0] IDX_T2_HI = 13'h1013;
	localparam logic [TDT_IDX_W-1:0] IDX_T2_LO = 13'h1014;
	localparam logic [TDT_IDX_W-1:0] IDX_T2_CTRL = 13'h1015;
	localparam logic [TDT_IDX_W-1:0] IDX_T3_HI = 13'h1016;
	localparam logic [TDT_IDX_W-1:0] IDX_T3_LO = 13'h1017;
	localparam logic [TDT_IDX_W-1:0] IDX_T3_CTRL = 13'h1018;
	localparam logic [TDT_IDX_W-1:0] IDX_IRQ_STAT = 13'h1019;
	localparam logic [TDT_IDX_W-1:0] IDX_IRQ_MASK = 13'h101A;

	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [TDT_NT-1:0] STAT_RST = 3'h0;
	localparam logic [TDT_NT-1:0] MASK_RST = 3'h0;

	// Status register layout: sticky expiry bits low, live running bits above
	localparam int STAT_RUN_LSB = 4;

	// Control register layout
	typedef struct packed {
		logic start;
		logic wake_en;
		logic wake_rst;
		logic rsvd;
		logic loop;
		logic [2:0] clk_sel;
	} tdt_ctrl_t;

	// Register kinds for decode
	typedef enum logic [2:0] {
		KIND_NONE,
		KIND_HI,
		KIND_LO,
		KIND_CTRL,
		KIND_STAT,
		KIND_MASK
	} tdt_kind_t;

	typedef struct packed {
		tdt_kind_t kind;
		logic [1:0] tmr;
	} tdt_dec_t;

	// Clock source codes, first and second timer
	localparam logic [2:0] SEL12_PIN = 3'h0;
	localparam logic [2:0] SEL12_D16 = 3'h1;
	localparam logic [2:0] SEL12_D14 = 3'h2;
	localparam logic [2:0] SEL12_D10 = 3'h3;
	localparam logic [2:0] SEL12_D6 = 3'h4;
	localparam logic [2:0] SEL12_D2 = 3'h5;
	localparam logic [2:0] SEL12_32K = 3'h6;

	// Clock source codes, third timer
	localparam logic [2:0] SEL3_D16 = 3'h0;
	localparam logic [2:0] SEL3_D14 = 3'h1;
	localparam logic [2:0] SEL3_D10 = 3'h2;
	localparam logic [2:0] SEL3_D6 = 3'h3;
	localparam logic [2:0] SEL3_D2 = 3'h4;
	localparam logic [2:0] SEL3_D1 = 3'h5;
	localparam logic [2:0] SEL3_UNDIV = 3'h6;

	// Prescaler exponents
	localparam int EXP_16 = 16;
	localparam int EXP_14 = 14;
	localparam int EXP_10 = 10;
	localparam int EXP_6 = 6;
	localparam int EXP_2 = 2;
	localparam int EXP_1 = 1;

	// Bus constants
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : tdt_pkg

/* File: logic/tdt_timer_core.sv */
// One 12-bit down counting channel with auto reload and once or loop expiry
`timescale 1ns/1ps
module tdt_timer_core
	import tdt_pkg::*;
#(
	parameter int CNT_W = TDT_CNT_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic enable,
	input wire logic start_pulse,
	input wire logic loop,
	input wire logic tick,
	input wire logic [CNT_W-1:0] period,
	// State
	output logic [CNT_W-1:0] count,
	output logic running,
	output logic expire
);

	logic [CNT_W-1:0] count_reg;
	logic running_reg;
	logic expire_reg;
	logic last_tick;

	// Zero period expires on every tick rather than wrapping
	assign last_tick = (count_reg <= CNT_W'(1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
			running_reg <= 1'b0;
			expire_reg <= 1'b0;
		end else begin
			expire_reg <= 1'b0;
			// start wins, enable still shows the old bit then
			if (start_pulse) begin
				running_reg <= 1'b1;
				count_reg <= period;
			end else if (!enable) begin
				running_reg <= 1'b0;
			end else if (running_reg && tick) begin
				if (!last_tick) begin
					count_reg <= count_reg - CNT_W'(1);
				end else begin
					count_reg <= period;
					expire_reg <= 1'b1;
					if (!loop) begin
						running_reg <= 1'b0;
					end
				end
			end
		end
	end

	assign count = count_reg;
	assign running = running_reg;
	assign expire = expire_reg;

endmodule : tdt_timer_core

/* File: logic/tdt_timer_top.sv */
// Triple 12-bit down timer with AHB-Lite register slave, prescaler and interrupt logic
`timescale 1ns/1ps
module tdt_timer_top
	import tdt_pkg::*;
#(
	parameter int NT = TDT_NT,
	parameter int CNT_W = TDT_CNT_W,
	parameter int PRE_W = TDT_PRE_W
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Timer clock sources, synchronous levels
	input wire logic user_divided_clock,
	input wire logic crystal_32k_clk,
	input wire logic port1_bit0_pin,
	// Power state
	input wire logic sleep_mode,
	// Events
	output logic irq,
	output logic wakeup_req,
	output logic wakeup_reset_req,
	output logic [NT-1:0] timer_expire
);

	// Source edge detection
	logic udc_d_reg;
	logic k32_d_reg;
	logic pin_d_reg;
	logic udc_edge;
	logic k32_edge;
	logic pin_edge;
	logic [PRE_W-1:0] presc_reg;

	// Bus state
	logic hready_reg;
	logic [31:0] hrdata_reg;
	logic wr_pend_reg;
	logic rd_pend_reg;
	tdt_dec_t acc_dec_reg;
	tdt_dec_t addr_dec;
	logic addr_phase;
	logic wr_hit;

	// Registers
	tdt_ctrl_t ctrl_reg [NT];
	logic [TDT_HI_W-1:0] per_hi_reg [NT];
	logic [TDT_LO_W-1:0] per_lo_reg [NT];
	logic [NT-1:0] stat_reg;
	logic [NT-1:0] stat_next;
	logic [NT-1:0] mask_reg;
	logic [NT-1:0] stat_clr;

	// Timer wires
	logic [NT-1:0] tick;
	logic [NT-1:0] start_pulse;
	logic [NT-1:0] running;
	logic [NT-1:0] expire;
	logic [NT-1:0] wake_en;
	logic [NT-1:0] wake_rst;

	// Outputs
	logic irq_reg;
	logic wake_reg;
	logic wake_rst_reg;
	logic [NT-1:0] expire_reg;
	logic [31:0] rd_mux;

	// Address decode, shared by read and write paths
	function automatic tdt_dec_t decode(input logic [TDT_IDX_W-1:0] idx);
		tdt_dec_t d;
		d.kind = KIND_NONE;
		d.tmr = 2'h0;
		if (idx == IDX_T1_HI) begin
			d = '{KIND_HI, 2'h0};
		end else if (idx == IDX_T1_LO) begin
			d = '{KIND_LO, 2'h0};
		end else if (idx == IDX_T1_CTRL) begin
			d = '{KIND_CTRL, 2'h0};
		end else if (idx == IDX_T2_HI) begin
			d = '{KIND_HI, 2'h1};
		end else if (idx == IDX_T2_LO) begin
			d = '{KIND_LO, 2'h1};
		end else if (idx == IDX_T2_CTRL) begin
			d = '{KIND_CTRL, 2'h1};
		end else if (idx == IDX_T3_HI) begin
			d = '{KIND_HI, 2'h2};
		end else if (idx == IDX_T3_LO) begin
			d = '{KIND_LO, 2'h2};
		end else if (idx == IDX_T3_CTRL) begin
			d = '{KIND_CTRL, 2'h2};
		end else if (idx == IDX_IRQ_STAT) begin
			d = '{KIND_STAT, 2'h0};
		end else if (idx == IDX_IRQ_MASK) begin
			d = '{KIND_MASK, 2'h0};
		end
		return d;
	endfunction : decode

	// Prescaler tap: one tick when the low exp bits roll over
	// Sources come in as arguments: a continuous caller only wakes on its operands
	function automatic logic tap(
		input int exp_n,
		input logic src_edge,
		input logic [PRE_W-1:0] pre_cnt
	);
		logic [PRE_W-1:0] m;
		m = PRE_W'((32'h1 << exp_n) - 32'h1);
		return src_edge && ((pre_cnt & m) == m);
	endfunction : tap

	// Tick for a timer from its clock select code
	function automatic logic sel_tick(
		input int idx,
		input logic [2:0] sel,
		input logic src_udc,
		input logic src_k32,
		input logic src_pin,
		input logic [PRE_W-1:0] pre_cnt
	);
		logic t;
		t = 1'b0;
		if (idx < 2) begin
			case (sel)
				SEL12_PIN: t = src_pin;
				SEL12_D16: t = tap(EXP_16, src_udc, pre_cnt);
				SEL12_D14: t = tap(EXP_14, src_udc, pre_cnt);
				SEL12_D10: t = tap(EXP_10, src_udc, pre_cnt);
				SEL12_D6: t = tap(EXP_6, src_udc, pre_cnt);
				SEL12_D2: t = tap(EXP_2, src_udc, pre_cnt);
				SEL12_32K: t = src_k32;
				default: t = 1'b0;
			endcase
		end else begin
			case (sel)
				SEL3_D16: t = tap(EXP_16, src_udc, pre_cnt);
				SEL3_D14: t = tap(EXP_14, src_udc, pre_cnt);
				SEL3_D10: t = tap(EXP_10, src_udc, pre_cnt);
				SEL3_D6: t = tap(EXP_6, src_udc, pre_cnt);
				SEL3_D2: t = tap(EXP_2, src_udc, pre_cnt);
				SEL3_D1: t = tap(EXP_1, src_udc, pre_cnt);
				SEL3_UNDIV: t = src_udc;
				default: t = src_k32;
			endcase
		end
		return t;
	endfunction : sel_tick

	// Sources are slow levels already in this domain; rising edges count
	assign udc_edge = user_divided_clock && !udc_d_reg;
	assign k32_edge = crystal_32k_clk && !k32_d_reg;
	assign pin_edge = port1_bit0_pin && !pin_d_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			udc_d_reg <= 1'b0;
			k32_d_reg <= 1'b0;
			pin_d_reg <= 1'b0;
			presc_reg <= '0;
		end else begin
			udc_d_reg <= user_divided_clock;
			k32_d_reg <= crystal_32k_clk;
			pin_d_reg <= port1_bit0_pin;
			if (udc_edge) begin
				presc_reg <= presc_reg + PRE_W'(1);
			end
		end
	end

	// Bus address phase
	assign addr_phase = hsel && htrans[1] && hready;
	assign addr_dec = decode(haddr[TDT_IDX_W+1:2]);
	assign wr_hit = wr_pend_reg;

	// Reads take one wait state so a write just before is already stored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hready_reg <= 1'b1;
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			acc_dec_reg <= '{KIND_NONE, 2'h0};
			hrdata_reg <= RDATA_ZERO;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
			rd_pend_reg <= addr_phase && !hwrite;
			if (addr_phase) begin
				acc_dec_reg <= addr_dec;
			end
			hready_reg <= !(addr_phase && !hwrite);
			if (rd_pend_reg) begin
				hrdata_reg <= rd_mux;
			end
		end
	end

	// Read selection; unmapped reads return zero
	always_comb begin
		rd_mux = RDATA_ZERO;
		case (acc_dec_reg.kind)
			KIND_HI: rd_mux = 32'(per_hi_reg[acc_dec_reg.tmr]);
			KIND_LO: rd_mux = 32'(per_lo_reg[acc_dec_reg.tmr]);
			KIND_CTRL: rd_mux = 32'({ctrl_reg[acc_dec_reg.tmr].start,
				wake_en[acc_dec_reg.tmr], wake_rst[acc_dec_reg.tmr], 1'b0,
				ctrl_reg[acc_dec_reg.tmr].loop, ctrl_reg[acc_dec_reg.tmr].clk_sel});
			KIND_STAT: rd_mux = (32'(running) << STAT_RUN_LSB) | 32'(stat_reg);
			KIND_MASK: rd_mux = 32'(mask_reg);
			default: rd_mux = RDATA_ZERO;
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < NT; gi++) begin : g_tmr
			logic sel_ctrl;
			logic sel_hi;
			logic sel_lo;
			assign sel_ctrl = wr_hit && acc_dec_reg.kind == KIND_CTRL && acc_dec_reg.tmr == 2'(gi);
			assign sel_hi = wr_hit && acc_dec_reg.kind == KIND_HI && acc_dec_reg.tmr == 2'(gi);
			assign sel_lo = wr_hit && acc_dec_reg.kind == KIND_LO && acc_dec_reg.tmr == 2'(gi);
			assign tick[gi] = sel_tick(gi, ctrl_reg[gi].clk_sel, udc_edge, k32_edge, pin_edge, presc_reg);
			assign start_pulse[gi] = sel_ctrl && hwdata[7];
			assign wake_en[gi] = (gi < 2) ? ctrl_reg[gi].wake_en : 1'b0;
			assign wake_rst[gi] = (gi < 2) ? ctrl_reg[gi].wake_rst : 1'b0;

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					ctrl_reg[gi] <= CTRL_RST;
				end else if (sel_ctrl) begin
					ctrl_reg[gi] <= tdt_ctrl_t'(hwdata[7:0]);
				end
			end

			always_ff @(posedge hclk) begin
				if (sel_hi) begin
					per_hi_reg[gi] <= hwdata[TDT_HI_W-1:0];
				end
				if (sel_lo) begin
					per_lo_reg[gi] <= hwdata[TDT_LO_W-1:0];
				end
			end

			tdt_timer_core #(
				.CNT_W(CNT_W)
			) u_core (
				.clk(hclk),
				.rst_n(hresetn),
				.enable(ctrl_reg[gi].start),
				.start_pulse(start_pulse[gi]),
				.loop(ctrl_reg[gi].loop),
				.tick(tick[gi]),
				.period(CNT_W'({per_hi_reg[gi], per_lo_reg[gi]})),
				.count(),
				.running(running[gi]),
				.expire(expire[gi])
			);
		end
	endgenerate

	// Write one to clear; a new expiry in the same cycle wins
	assign stat_clr = (wr_hit && acc_dec_reg.kind == KIND_STAT) ? hwdata[NT-1:0] : '0;
	assign stat_next = (stat_reg & ~stat_clr) | expire;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_reg <= STAT_RST;
			mask_reg <= MASK_RST;
		end else begin
			stat_reg <= stat_next;
			if (wr_hit && acc_dec_reg.kind == KIND_MASK) begin
				mask_reg <= hwdata[NT-1:0];
			end
		end
	end

	// Event outputs, one cycle behind their causes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			wake_rst_reg <= 1'b0;
			expire_reg <= '0;
		end else begin
			irq_reg <= |(stat_reg & mask_reg);
			expire_reg <= expire;
			wake_reg <= sleep_mode && |(expire & wake_en);
			wake_rst_reg <= sleep_mode && |(expire & wake_en & wake_rst);
		end
	end

	assign hreadyout = hready_reg;
	assign hresp = HRESP_OKAY;
	assign hrdata = hrdata_reg;
	assign irq = irq_reg;
	assign wakeup_req = wake_reg;
	assign wakeup_reset_req = wake_rst_reg;
	assign timer_expire = expire_reg;

endmodule : tdt_timer_top

/* File: sim/tdt_timer_chk.sv */
// Bus and event checker for the triple down timer
`timescale 1ns/1ps
module tdt_timer_chk
	import tdt_pkg::*;
#(
	parameter int NT = TDT_NT
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Events
	input wire logic irq,
	input wire logic wakeup_req,
	input wire logic wakeup_reset_req,
	input wire logic [NT-1:0] timer_expire
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic acc = hsel && htrans[1] && hready;
	// Unmasking a pending status also raises the request
	wire logic mask_wr = acc && hwrite && (haddr[TDT_IDX_W+1:2] == IDX_IRQ_MASK);
	a_resp_okay:
		assert property (hresp == HRESP_OKAY) else $error("bad response");
	a_write_nowait:
		assert property (acc && hwrite |=> hreadyout) else $error("write stalled");
	a_read_onewait:
		assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	// Read data moves only as a read completes
	a_rdata_hold:
		assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0) else $error("read data moved");
	a_reset_quiet:
		assert property ($rose(hresetn) |-> hreadyout && !irq && timer_expire == '0) else $error("not quiet");
	a_expire_pulse:
		assert property ((timer_expire & $past(timer_expire)) == '0) else $error("expiry not a pulse");
	a_wake_cause:
		assert property (wakeup_req |-> timer_expire[1:0] != 2'h0) else $error("wake without expiry");
	a_wreset_wake:
		assert property (wakeup_reset_req |-> wakeup_req) else $error("reset without wake");
	a_irq_source:
		assert property ($rose(irq) |-> ($past(timer_expire) != '0) || $past(mask_wr, 3)) else $error("irq without cause");
endmodule : tdt_timer_chk

bind tdt_timer_top tdt_timer_chk #(.NT(NT)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .hrdata, .irq, .wakeup_req, .wakeup_reset_req, .timer_expire);

/* File: sim/tdt_host_bfm.sv */
// Processor side bus master model for the triple down timer
`timescale 1ns/1ps
module tdt_host_bfm
	import tdt_pkg::*;
(
	// Clock and answer
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	task automatic xfer(input logic [TDT_IDX_W-1:0] i, input logic w, input logic [31:0] d, output logic [31:0] q);
		haddr <= {17'h00000, i, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		// Stale data inverted so a late sample shows
		hwdata <= ~d;
	endtask : xfer
endmodule : tdt_host_bfm

/* File: sim/tb_triple_12bit_down_timer.sv */
// Self-checking bench for the triple down timer
`timescale 1ns/1ps
module tb_triple_12bit_down_timer
	import tdt_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, irq, wakeup_req, wakeup_reset_req;
	logic [1:0] htrans;
	logic [2:0] hsize, timer_expire;
	logic [31:0] haddr, hwdata, hrdata;
	logic user_divided_clock = 1'b0;
	logic crystal_32k_clk = 1'b0;
	logic port1_bit0_pin = 1'b0;
	logic sleep_mode = 1'b1;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	int nw = 0;
	int nr = 0;
	logic [12:0] ri[5] = '{IDX_T1_CTRL, IDX_T2_CTRL, IDX_T3_CTRL, IDX_IRQ_STAT, IDX_IRQ_MASK};
	// Timer, select, extra control bits, hclk per tick (0: none)
	int tab[13] = '{32'h0000000A, 32'h05600010, 32'h06000006, 32'h03001000, 32'h07000000,
		32'h1040000A, 32'h14200100, 32'h17000000, 32'h24600010, 32'h25000008,
		32'h26000004, 32'h27000006, 32'h23000100};
	tdt_host_bfm u_host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
	tdt_timer_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .user_divided_clock, .crystal_32k_clk,
		.port1_bit0_pin, .sleep_mode, .irq, .wakeup_req, .wakeup_reset_req, .timer_expire);
	initial forever #12.5 hclk = ~hclk;
	// Sources: user clock 4, crystal 6, pin 10 cycles
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		user_divided_clock <= cyc[1];
		crystal_32k_clk <= (cyc % 6) < 3;
		port1_bit0_pin <= (cyc % 10) < 5;
		if (wakeup_req === 1'b1) nw++;
		if (wakeup_reset_req === 1'b1) nr++;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [12:0] i, input logic [31:0] d);
		logic [31:0] q;
		u_host.xfer(i, 1'b1, d, q);
	endtask : wr
	task automatic rdc(input string nm, input logic [12:0] i, input logic [31:0] e);
		logic [31:0] q;
		u_host.xfer(i, 1'b0, 32'h0, q);
		chk(nm, e, q);
	endtask : rdc
	// Cycle stamp of the next expiry, -1 if none
	task automatic nxt(input int t, input int lim, output int st);
		st = -1;
		for (int k = 0; k < lim && st < 0; k++) begin
			@(posedge hclk);
			if (timer_expire[t] === 1'b1) st = cyc;
		end
	endtask : nxt
	task automatic cnt(input int t, input int lim, output int c);
		c = 0;
		repeat (lim) begin
			@(posedge hclk);
			if (timer_expire[t] === 1'b1) c++;
		end
	endtask : cnt
	initial begin
		repeat (100000) @(posedge hclk);
		n_mismatch++;
		$display("FAIL watchdog expected end seen timeout");
		summarize();
	end
	initial begin
		int s1, s2, c, t, p;
		logic [7:0] x, cv;
		logic [12:0] b;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (ri[i]) rdc("reset value", ri[i], 32'h0);
		wr(13'h0FFF, 32'hFFFF_FFFF);
		rdc("unmapped", 13'h0FFF, 32'h0);
		wr(IDX_T1_HI, 32'hFFFF_FFFF);
		rdc("high width", IDX_T1_HI, 32'h0000_000F);
		wr(IDX_T2_LO, 32'h0000_01A5);
		rdc("low width", IDX_T2_LO, 32'h0000_00A5);
		$display("test registers done");
		foreach (tab[i]) begin
			t = tab[i][31:28];
			p = tab[i][15:0];
			x = 8'h88 | tab[i][23:16] | {5'h00, tab[i][26:24]};
			b = IDX_T1_HI + 13'(3 * t);
			wr(b, 32'h0);
			wr(b + 13'h1, 32'h2);
			nw = 0;
			nr = 0;
			wr(b + 13'h2, {24'h0, x});
			cv = (t == 2) ? (x & 8'h8F) : x;
			rdc("control", b + 13'h2, {24'h0, cv});
			if (p == 0) begin
				cnt(t, 200, c);
				chk("grounded", 0, c);
			end else begin
				nxt(t, 6 * p + 64, s1);
				nxt(t, 6 * p + 64, s2);
				chk("interval", 2 * p, s2 - s1);
			end
			chk("wake", t < 2 && x[6], nw > 0);
			chk("wake reset", t < 2 && x[6] && x[5], nr > 0);
			wr(b + 13'h2, 32'h0);
			repeat (2) @(posedge hclk);
			cnt(t, 40, c);
			chk("stopped", 0, c);
		end
		rdc("sticky", IDX_IRQ_STAT, 32'h7);
		wr(IDX_IRQ_STAT, 32'h7);
		rdc("cleared", IDX_IRQ_STAT, 32'h0);
		$display("test clock select done");
		sleep_mode <= 1'b0;
		nw = 0;
		wr(IDX_IRQ_MASK, 32'h1);
		wr(IDX_T1_CTRL, 32'hE5);
		nxt(0, 100, s1);
		repeat (3) @(posedge hclk);
		chk("irq raised", 1, irq);
		cnt(0, 100, c);
		chk("one shot", 0, c);
		rdc("one shot stopped", IDX_IRQ_STAT, 32'h1);
		chk("sleep gate", 0, nw);
		wr(IDX_IRQ_MASK, 32'h0);
		repeat (2) @(posedge hclk);
		chk("irq masked", 0, irq);
		wr(IDX_IRQ_STAT, 32'h1);
		wr(IDX_IRQ_MASK, 32'h1);
		repeat (2) @(posedge hclk);
		chk("irq cleared", 0, irq);
		wr(IDX_T1_CTRL, 32'hE5);
		nxt(0, 100, s1);
		chk("restart", 1, s1 > 0);
		$display("test one shot and interrupt done");
		summarize();
	end
endmodule : tb_triple_12bit_down_timer
